// [cmi_map.svh]
// offsets, field positions, opcodes and reset values of the sequencer
`ifndef CMI_MAP_SVH
`define CMI_MAP_SVH
// apb register byte offsets
`define CMI_OFF_CTRL    12'h000
`define CMI_OFF_SWITCH  12'h004
`define CMI_OFF_STATUS  12'h008
`define CMI_OFF_AC      12'h00C
`define CMI_OFF_PC      12'h010
// control register fields
`define CMI_CTL_RUN     0
`define CMI_CTL_CEXEC   1
`define CMI_CTL_MSEL    2
`define CMI_CTL_PRESET  3
// reset values
`define CMI_WORD_RST    12'h000
`define CMI_PRD_RST     32'h0000_0000
// opcodes, instruction bits 00-02
`define CMI_OP_AND      3'h0
`define CMI_OP_ADD      3'h1
`define CMI_OP_INCSKIP  3'h2
`define CMI_OP_DEPOSIT  3'h3
`define CMI_OP_CALL     3'h4
`define CMI_OP_JUMP     3'h5
`define CMI_OP_IO       3'h6
`define CMI_OP_OPERATE  3'h7
// word bit positions as vector indices, bit 0 is the lsb (bit 11 in the msb-first numbering)
`define CMI_B_IND       8
`define CMI_B_PAGE      7
`define CMI_B_CLRAC     7
`define CMI_B_CLL       6
`define CMI_B_CMPAC     5
`define CMI_B_CML       4
`define CMI_B_HLT       1
`define CMI_B_INCAC     0
// auto-index window
`define CMI_AUTO_LO     12'h008
`define CMI_AUTO_HI     12'h00F
`endif

// [cmi_pkg.sv]
// types of the classic mode sequencer
package cmi_pkg;
  typedef enum logic [2:0] {
    MAJ_FETCH = 3'b001,
    MAJ_DEFER = 3'b010,
    MAJ_EXEC  = 3'b100
  } cmi_maj_t;
  typedef enum logic [4:0] {
    TS_1 = 5'b00001,
    TS_2 = 5'b00010,
    TS_3 = 5'b00100,
    TS_4 = 5'b01000,
    TS_5 = 5'b10000
  } cmi_ts_t;
endpackage

// [cmi_adder.sv]
// twelve bit adder with carry insert into bit 11
`timescale 1ns/1ps
module cmi_adder (
  // operands
  input  wire logic [11:0] add_a,
  input  wire logic [11:0] add_b,
  input  wire logic        carry_in,
  // result
  output logic      [11:0] add_sum,
  output logic             carry_out
);
  // carry out of bit 00 is the thirteenth bit
  assign {carry_out, add_sum} = {1'b0, add_a} + {1'b0, add_b}
                              + {12'h000, carry_in};
endmodule // cmi_adder

// [cmi_core.sv]
// classic mode fetch, defer and execute sequencer with apb control
//
// Functional notes
// - power clear forces classic mode
// - preset with classic selected leaves alternate mode
// - console execute loads switches, pc holds
// - fetch advances pc at pulse two, clears ir
// - pulse three clears skip, halt; loads buffer, ir
// - t4 decodes class, qualified by mode
// - bit 03 selects defer, else execute, except a direct jump
// - page zero address from bits 5-11
// - bit 04 set selects current page
// - pointers 0010-0017 auto-increment on read
// - defer jump loads pc, else execute
// - direct execute forms address like defer
// - execute after defer loads buffer into ma
// - execute t2 reads operand, t3 loads it into buffer
// - and via complement, or, complement
// - add sums into ac and link
// - increment-skip adds one, carry sets skip
// - set skip increments next fetch address
// - deposit stores ac then clears it
// - subroutine jump stores pc, jumps past
// - operate completes within one cycle
// - operate decode; bit 03 zero class one
// - clear plus complement gives all ones
// - increment bit inserts carry at pulse four
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "cmi_map.svh"
module cmi_core (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core memory, same clock domain
  output logic      [11:0] mem_addr,
  output logic      [11:0] mem_wdata,
  output logic             mem_rd,
  output logic             mem_wr,
  input  wire logic [11:0] mem_rdata,
  input  wire logic        mem_ack,
  // status
  output logic             classic_mode,
  output logic             running
);
  // operand address on current page or page zero
  function automatic logic [11:0] page_addr(input logic [11:0] cur,
                                            input logic        pg,
                                            input logic [6:0]  lo);
    page_addr = pg ? {cur[11:7], lo} : {5'h00, lo};
  endfunction

  // memory reference decode, gated by the mode flip-flop
  function automatic logic is_memref(input logic md, input logic [2:0] op);
    is_memref = md & (op < `CMI_OP_IO);
  endfunction

  cmi_pkg::cmi_maj_t maj_reg, maj_next;
  cmi_pkg::cmi_ts_t  ts_reg, ts_next;
  logic [11:0] pc_reg, pc_next, ma_reg, ma_next, buf_reg, buf_next;
  logic [11:0] ac_reg, ac_next, rdat_reg, rdat_next;
  logic [4:0]  ir_reg, ir_next;
  logic        link_reg, link_next, skip_reg, skip_next;
  logic        halt_reg, halt_next, mode_reg, mode_next;
  logic        cexec_reg, cexec_next, run_reg, run_next;
  logic        fromdef_reg, fromdef_next;
  logic [11:0] switch_reg, switch_next;
  logic        msel_reg, msel_next;
  logic [31:0] prd_reg, prd_next;
  logic [11:0] add_a, add_b, add_sum, opv;
  logic        add_ci, add_co, lnk1;
  logic        apb_wr, hit, ctl_wr, pc_wr, switch_wr;
  logic        rd_need, wr_need, adv, auto_hit;
  logic        memref, operate, jump, cls1;
  logic [2:0]  op;

  // instruction decode during the cycle
  assign op   = ir_reg[4:2];
  assign memref  = is_memref(mode_reg, op);
  assign operate = mode_reg & (op == `CMI_OP_OPERATE);
  assign jump    = memref & (op == `CMI_OP_JUMP);
  assign cls1    = operate & ~ir_reg[1];
  assign auto_hit = (ma_reg >= `CMI_AUTO_LO) & (ma_reg <= `CMI_AUTO_HI);

  // memory traffic; a console fetch takes the switches, not memory
  assign rd_need = (maj_reg != cmi_pkg::MAJ_FETCH) | ~cexec_reg;
  assign wr_need = ((maj_reg == cmi_pkg::MAJ_DEFER) & auto_hit)
                 | ((maj_reg == cmi_pkg::MAJ_EXEC)
                    & ((op == `CMI_OP_INCSKIP) | (op == `CMI_OP_DEPOSIT)
                       | (op == `CMI_OP_CALL)));
  assign mem_addr  = ma_reg;
  assign mem_wdata = buf_reg;
  assign mem_rd = run_reg & (ts_reg == cmi_pkg::TS_2) & rd_need;
  assign mem_wr = run_reg & (ts_reg == cmi_pkg::TS_5) & wr_need;

  // while running, a time state ends each clock except while memory is busy
  always_comb begin
    adv = run_reg;
    if (ts_reg == cmi_pkg::TS_2 && rd_need)
      adv = run_reg & mem_ack;
    if (ts_reg == cmi_pkg::TS_5 && wr_need)
      adv = run_reg & mem_ack;
  end

  // operate class one: clear then complement, so both give ones
  always_comb begin
    opv  = buf_reg[`CMI_B_CLRAC] ? 12'h000 : ac_reg;
    opv  = buf_reg[`CMI_B_CMPAC] ? ~opv : opv;
    lnk1 = buf_reg[`CMI_B_CLL] ? 1'b0 : link_reg;
    lnk1 = buf_reg[`CMI_B_CML] ? ~lnk1 : lnk1;
  end

  // one shared adder; the operand mux follows the time state
  always_comb begin
    add_a  = ma_reg;
    add_b  = 12'h000;
    add_ci = 1'b0;
    case (ts_reg)
      cmi_pkg::TS_1: begin
        add_a  = pc_reg;
        add_ci = skip_reg;
      end
      cmi_pkg::TS_2: add_ci = 1'b1;
      cmi_pkg::TS_3: begin
        add_a  = rdat_reg;
        add_ci = (maj_reg == cmi_pkg::MAJ_DEFER) ? auto_hit : 1'b1;
      end
      cmi_pkg::TS_4: begin
        if (maj_reg == cmi_pkg::MAJ_FETCH) begin
          add_a  = opv;
          add_ci = buf_reg[`CMI_B_INCAC];
        end else if (op == `CMI_OP_ADD) begin
          add_a = ac_reg;
          add_b = buf_reg;
        end else begin
          add_ci = 1'b1;
        end
      end
      default: add_ci = 1'b0;
    endcase
  end

  cmi_adder u_adder (
    .add_a     (add_a),
    .add_b     (add_b),
    .carry_in  (add_ci),
    .add_sum   (add_sum),
    .carry_out (add_co)
  );

  // apb decode; zero wait states, unmapped access errors
  assign pready = 1'b1;
  assign hit = (paddr == `CMI_OFF_CTRL) | (paddr == `CMI_OFF_SWITCH)
             | (paddr == `CMI_OFF_STATUS) | (paddr == `CMI_OFF_AC)
             | (paddr == `CMI_OFF_PC);
  assign pslverr = psel & penable & ~hit;
  assign apb_wr  = psel & penable & pwrite;
  assign ctl_wr  = apb_wr & (paddr == `CMI_OFF_CTRL);
  assign switch_wr = apb_wr & (paddr == `CMI_OFF_SWITCH);
  // pc is only loadable while stopped, else a running fetch races it
  assign pc_wr   = apb_wr & (paddr == `CMI_OFF_PC) & ~run_reg;
  assign prdata  = prd_reg;

  // apb state: switches, mode selector and read data
  always_comb begin
    switch_next = switch_reg;
    msel_next = msel_reg;
    prd_next  = prd_reg;
    if (switch_wr)
      switch_next = pwdata[11:0];
    if (ctl_wr)
      msel_next = pwdata[`CMI_CTL_MSEL];
    if (psel && !penable) begin
      case (paddr)
        `CMI_OFF_CTRL:   prd_next = {29'h0, msel_reg, cexec_reg, run_reg};
        `CMI_OFF_SWITCH: prd_next = {20'h0, switch_reg};
        `CMI_OFF_STATUS: prd_next = {20'h0, mode_reg, link_reg, skip_reg,
                                     halt_reg, ts_reg, maj_reg};
        `CMI_OFF_AC:     prd_next = {20'h0, ac_reg};
        `CMI_OFF_PC:     prd_next = {20'h0, pc_reg};
        default:         prd_next = `CMI_PRD_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      switch_reg <= `CMI_WORD_RST;
      msel_reg <= 1'b1;
      prd_reg  <= `CMI_PRD_RST;
    end else begin
      switch_reg <= switch_next;
      msel_reg <= msel_next;
      prd_reg  <= prd_next;
    end
  end

  // processor state: major state, time state and registers
  always_comb begin
    maj_next = maj_reg;
    ts_next  = ts_reg;
    pc_next  = pc_reg;
    ma_next  = ma_reg;
    buf_next = buf_reg;
    ac_next  = ac_reg;
    ir_next  = ir_reg;
    rdat_next = rdat_reg;
    link_next = link_reg;
    skip_next = skip_reg;
    halt_next = halt_reg;
    mode_next = mode_reg;
    cexec_next = cexec_reg;
    run_next  = run_reg;
    fromdef_next = fromdef_reg;
    if (pc_wr)
      pc_next = pwdata[11:0];
    if (ctl_wr) begin
      run_next = pwdata[`CMI_CTL_RUN];
      if (pwdata[`CMI_CTL_PRESET])
        mode_next = pwdata[`CMI_CTL_MSEL];
    end
    if (adv) begin
      case (ts_reg)
        cmi_pkg::TS_1: begin
          ts_next = cmi_pkg::TS_2;
          case (maj_reg)
            cmi_pkg::MAJ_FETCH: ma_next = add_sum;
            cmi_pkg::MAJ_DEFER:
              ma_next = page_addr(ma_reg, buf_reg[`CMI_B_PAGE],
                                  buf_reg[6:0]);
            cmi_pkg::MAJ_EXEC:
              ma_next = fromdef_reg ? buf_reg
                      : page_addr(ma_reg, ir_reg[0], buf_reg[6:0]);
            default: ma_next = ma_reg;
          endcase
        end
        cmi_pkg::TS_2: begin
          ts_next = cmi_pkg::TS_3;
          if (rd_need)
            rdat_next = mem_rdata;
          if (maj_reg == cmi_pkg::MAJ_FETCH && !cexec_reg) begin
            pc_next = add_sum;
            ir_next = 5'h00;
          end
        end
        cmi_pkg::TS_3: begin
          ts_next = cmi_pkg::TS_4;
          case (maj_reg)
            cmi_pkg::MAJ_FETCH: begin
              skip_next = 1'b0;
              halt_next = 1'b0;
              buf_next = cexec_reg ? switch_reg : rdat_reg;
              ir_next = cexec_reg ? switch_reg[11:7] : rdat_reg[11:7];
            end
            cmi_pkg::MAJ_DEFER: buf_next = add_sum;
            cmi_pkg::MAJ_EXEC: begin
              case (op)
                `CMI_OP_INCSKIP: begin
                  buf_next = add_sum;
                  skip_next = add_co;
                end
                `CMI_OP_DEPOSIT: buf_next = ac_reg;
                `CMI_OP_CALL:    buf_next = pc_reg;
                default:         buf_next = rdat_reg;
              endcase
            end
            default: buf_next = buf_reg;
          endcase
        end
        cmi_pkg::TS_4: begin
          ts_next = cmi_pkg::TS_5;
          case (maj_reg)
            cmi_pkg::MAJ_FETCH: begin
              if (cls1) begin
                ac_next   = add_sum;
                link_next = lnk1 ^ add_co;
              end else if (operate && buf_reg[`CMI_B_HLT]) begin
                halt_next = 1'b1;
              end
              if (jump && !ir_reg[1])
                pc_next = page_addr(ma_reg, ir_reg[0], buf_reg[6:0]);
            end
            cmi_pkg::MAJ_DEFER:
              if (jump)
                pc_next = buf_reg;
            cmi_pkg::MAJ_EXEC: begin
              case (op)
                `CMI_OP_AND: ac_next = ~ac_reg | ~buf_reg;
                `CMI_OP_ADD: begin
                  ac_next   = add_sum;
                  link_next = link_reg ^ add_co;
                end
                `CMI_OP_DEPOSIT: ac_next = 12'h000;
                `CMI_OP_CALL:    pc_next = add_sum;
                default:     ac_next = ac_reg;
              endcase
            end
            default: ac_next = ac_reg;
          endcase
        end
        cmi_pkg::TS_5: begin
          ts_next = cmi_pkg::TS_1;
          fromdef_next = (maj_reg == cmi_pkg::MAJ_DEFER);
          if (halt_reg)
            run_next = 1'b0;
          case (maj_reg)
            cmi_pkg::MAJ_FETCH: begin
              cexec_next = 1'b0;
              if (memref && ir_reg[1])
                maj_next = cmi_pkg::MAJ_DEFER;
              else if (memref && !jump)
                maj_next = cmi_pkg::MAJ_EXEC;
            end
            cmi_pkg::MAJ_DEFER:
              maj_next = jump ? cmi_pkg::MAJ_FETCH
                             : cmi_pkg::MAJ_EXEC;
            cmi_pkg::MAJ_EXEC: begin
              maj_next = cmi_pkg::MAJ_FETCH;
              if (op == `CMI_OP_AND)
                ac_next = ~ac_reg;
            end
            default: maj_next = cmi_pkg::MAJ_FETCH;
          endcase
        end
        default: ts_next = cmi_pkg::TS_1;
      endcase
    end
    // a console request landing on its own clear is kept
    if (ctl_wr && pwdata[`CMI_CTL_CEXEC])
      cexec_next = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      maj_reg  <= cmi_pkg::MAJ_FETCH;
      ts_reg   <= cmi_pkg::TS_1;
      pc_reg   <= `CMI_WORD_RST;
      ma_reg   <= `CMI_WORD_RST;
      buf_reg  <= `CMI_WORD_RST;
      ac_reg   <= `CMI_WORD_RST;
      rdat_reg <= `CMI_WORD_RST;
      ir_reg   <= 5'h00;
      link_reg <= 1'b0;
      skip_reg <= 1'b0;
      halt_reg <= 1'b0;
      mode_reg <= 1'b1;
      cexec_reg <= 1'b0;
      run_reg  <= 1'b0;
      fromdef_reg <= 1'b0;
    end else begin
      maj_reg  <= maj_next;
      ts_reg   <= ts_next;
      pc_reg   <= pc_next;
      ma_reg   <= ma_next;
      buf_reg  <= buf_next;
      ac_reg   <= ac_next;
      rdat_reg <= rdat_next;
      ir_reg   <= ir_next;
      link_reg <= link_next;
      skip_reg <= skip_next;
      halt_reg <= halt_next;
      mode_reg <= mode_next;
      cexec_reg <= cexec_next;
      run_reg  <= run_next;
      fromdef_reg <= fromdef_next;
    end
  end

  assign classic_mode = mode_reg;
  assign running      = run_reg;

  // checks on the sequencing
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_fetch(cmi_pkg::cmi_ts_t t);
    adv && maj_reg == cmi_pkg::MAJ_FETCH && ts_reg == t;
  endsequence
  sequence s_exec(logic [2:0] o, cmi_pkg::cmi_ts_t t);
    adv && maj_reg == cmi_pkg::MAJ_EXEC && op == o && ts_reg == t;
  endsequence

  mode_after_reset_a: assert property (
    $rose(rst_n) |-> mode_reg) else $error("not classic after reset");
  preset_mode_a: assert property (
    ctl_wr && pwdata[`CMI_CTL_PRESET] && pwdata[`CMI_CTL_MSEL]
    |=> mode_reg) else $error("preset did not select classic");
  console_load_a: assert property (
    s_fetch(cmi_pkg::TS_3) and cexec_reg
    |=> buf_reg == $past(switch_reg) && pc_reg == $past(pc_reg))
    else $error("console word not loaded");
  pc_advance_a: assert property (
    s_fetch(cmi_pkg::TS_2) and !cexec_reg && !pc_wr
    |=> pc_reg == $past(ma_reg) + 12'h001 && ir_reg == 5'h00)
    else $error("pc not advanced");
  skip_clear_a: assert property (
    s_fetch(cmi_pkg::TS_3) |=> !skip_reg && !halt_reg)
    else $error("skip or halt not cleared");
  defer_entry_a: assert property (
    s_fetch(cmi_pkg::TS_5) and memref && ir_reg[1]
    |=> maj_reg == cmi_pkg::MAJ_DEFER) else $error("defer not entered");
  page_zero_a: assert property (
    adv && maj_reg == cmi_pkg::MAJ_DEFER && ts_reg == cmi_pkg::TS_1
    && !buf_reg[`CMI_B_PAGE]
    |=> ma_reg == {5'h00, $past(buf_reg[6:0])})
    else $error("page zero address wrong");
  auto_index_a: assert property (
    adv && maj_reg == cmi_pkg::MAJ_DEFER && ts_reg == cmi_pkg::TS_3
    && auto_hit |=> buf_reg == $past(rdat_reg) + 12'h001)
    else $error("pointer not incremented");
  incskip_write_a: assert property (
    s_exec(`CMI_OP_INCSKIP, cmi_pkg::TS_3) ##1 adv[*1] ##1 1'b1
    |-> mem_wr && mem_wdata == $past(buf_reg))
    else $error("incremented word not written back");
  deposit_clear_a: assert property (
    s_exec(`CMI_OP_DEPOSIT, cmi_pkg::TS_3)
    |=> buf_reg == $past(ac_reg) ##1 ac_reg == 12'h000)
    else $error("deposit did not clear ac");
endmodule // cmi_core

// [cmi_mem_model.sv]
// behavioural core memory answering the sequencer's read and write strobes
`timescale 1ns/1ps
module cmi_mem_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // request side
  input  wire logic [11:0] mem_addr,
  input  wire logic [11:0] mem_wdata,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  // answer side
  output logic      [11:0] mem_rdata,
  output logic             mem_ack
);
  logic [11:0] mem [0:4095];
  logic [1:0]  wait_cnt;
  logic [1:0]  slow;

  // blank store so stray reads return a defined word
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 12'h000;
    mem_rdata = 12'h000;
  end

  // latency cycles 0..3 so both prompt and slow answers occur
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_ack  <= 1'b0;
      wait_cnt <= 2'h0;
      slow     <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      // data is only good with the ack; a fresh pattern each cycle
      mem_rdata <= ~mem_rdata;
      if ((mem_rd || mem_wr) && !mem_ack) begin
        if (wait_cnt == slow) begin
          mem_ack  <= 1'b1;
          wait_cnt <= 2'h0;
          slow     <= slow + 2'h1;
          if (mem_wr) mem[mem_addr] <= mem_wdata;
          else mem_rdata <= mem[mem_addr];
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule // cmi_mem_model

// [classic_mode_instruction_cycles_tb_top.sv]
// self-checking bench running small programs on the sequencer
`timescale 1ns/1ps
`include "cmi_map.svh"
module classic_mode_instruction_cycles_tb_top;
  logic        clk_sys;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] mem_addr;
  logic [11:0] mem_wdata;
  logic        mem_rd;
  logic        mem_wr;
  logic [11:0] mem_rdata;
  logic        mem_ack;
  logic        classic_mode;
  logic        running;
  logic [31:0] rd_q;
  logic        rd_err;
  int          n_fail;
  int          num_checks;

  cmi_core cmi_core_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .classic_mode(classic_mode), .running(running));

  cmi_mem_model cmi_mem_model_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; setup, then access held until pready
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    rd_q   = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // start with the given control word and wait for the halt
  task run_prog(input logic [31:0] ctl);
    int n;
    apb(1'b1, `CMI_OFF_CTRL, ctl);
    n = 0;
    while (running !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (running !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    n = 0;
    while (running !== 1'b0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000) begin
      n_fail++;
      complete_run();
    end
  endtask

  function automatic logic [11:0] mem_ref(input logic [2:0] op,
      input logic ind, input logic pg, input logic [6:0] off);
    return {op, ind, pg, off};
  endfunction

  task ld(input logic [11:0] a, input logic [11:0] d);
    cmi_mem_model_inst.mem[a] = d;
  endtask

  // reset values, unmapped access and a read-only write
  task sc_reset;
    chk({31'h0, classic_mode}, 32'h1);
    chk({31'h0, running}, 32'h0);
    apb(1'b0, `CMI_OFF_PC, 32'h0);
    chk(rd_q, 32'h0);
    chk({31'h0, pready}, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    chk(rd_q, 32'h0);
    apb(1'b1, `CMI_OFF_AC, 32'h555);
    apb(1'b0, `CMI_OFF_AC, 32'h0);
    chk(rd_q, 32'h0);
    chk({31'h0, rd_err}, 32'h0);
  endtask

  // every memory reference kind, skip, auto-index, operate class one
  task sc_program;
    ld(12'h080, 12'hEA0);                  // clear and complement
    ld(12'h081, mem_ref(3'h0, 0, 1, 7'h40));
    ld(12'h082, mem_ref(3'h1, 0, 0, 7'h41));
    ld(12'h083, mem_ref(3'h3, 0, 1, 7'h41));
    ld(12'h084, mem_ref(3'h2, 0, 1, 7'h42));
    ld(12'h085, 12'hF02);                  // halt, must be skipped
    ld(12'h086, mem_ref(3'h1, 1, 0, 7'h08));
    ld(12'h087, 12'hE01);                  // increment
    ld(12'h088, mem_ref(3'h4, 0, 1, 7'h50));
    ld(12'h089, mem_ref(3'h5, 0, 1, 7'h0B));
    ld(12'h08A, 12'hF02);
    ld(12'h08B, 12'hF02);
    ld(12'h0D1, mem_ref(3'h5, 1, 1, 7'h50));
    ld(12'h0C0, 12'h5A3);
    ld(12'h041, 12'hA60);
    ld(12'h0C2, 12'hFFF);
    ld(12'h008, 12'h0C3);
    ld(12'h0C4, 12'h00F);
    apb(1'b1, `CMI_OFF_PC, 32'h080);
    run_prog(32'h5);
    apb(1'b0, `CMI_OFF_AC, 32'h0);
    chk(rd_q, 32'h010);
    apb(1'b0, `CMI_OFF_PC, 32'h0);
    chk(rd_q, 32'h08C);
    apb(1'b0, `CMI_OFF_STATUS, 32'h0);
    chk(rd_q, 32'hD09);
    chk({20'h0, cmi_mem_model_inst.mem[12'h0C1]}, 32'h003);
    chk({20'h0, cmi_mem_model_inst.mem[12'h0C2]}, 32'h000);
    chk({20'h0, cmi_mem_model_inst.mem[12'h008]}, 32'h0C4);
    chk({20'h0, cmi_mem_model_inst.mem[12'h0D0]}, 32'h089);
  endtask

  // switch word executed in place of memory, pc held for that fetch
  task sc_console;
    ld(12'h08C, 12'hF02);
    apb(1'b1, `CMI_OFF_SWITCH, 32'hE01);
    apb(1'b0, `CMI_OFF_SWITCH, 32'h0);
    chk(rd_q, 32'hE01);
    run_prog(32'h7);
    apb(1'b0, `CMI_OFF_AC, 32'h0);
    chk(rd_q, 32'h011);
    apb(1'b0, `CMI_OFF_PC, 32'h0);
    chk(rd_q, 32'h08D);
  endtask

  // mode selector applied by preset, both directions
  task sc_mode;
    apb(1'b1, `CMI_OFF_CTRL, 32'h8);
    @(posedge clk_sys);
    chk({31'h0, classic_mode}, 32'h0);
    apb(1'b1, `CMI_OFF_CTRL, 32'hC);
    @(posedge clk_sys);
    chk({31'h0, classic_mode}, 32'h1);
    apb(1'b0, `CMI_OFF_CTRL, 32'h0);
    chk(rd_q, 32'h4);
  endtask

  // inputs valued at time zero, reset held for ten cycles
  initial begin
    clk_sys    = 1'b0;
    rst_n      = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    n_fail     = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    sc_reset;
    sc_program;
    sc_console;
    sc_mode;
    complete_run;
  end
endmodule // classic_mode_instruction_cycles_tb_top
